// ==== shared/hdt_cfg.svh ====
`ifndef HDT_CFG_SVH
`define HDT_CFG_SVH
`define HDT_OFF_TOTAL_ACTIVE 16'h8330
`define HDT_OFF_BLANK_WINDOW 16'h8334
`define HDT_OFF_SYNC_WINDOW  16'h8338
`define HDT_ADDR_MSB         15
`define HDT_HI_MSB           26
`define HDT_HI_LSB           19
`define HDT_LO_MSB           10
`define HDT_LO_LSB           3
`define HDT_RESP_OKAY        2'h0
`define HDT_RESP_SLVERR      2'h2
`define HDT_PIX_PER_CHAR     4'h8
`endif

// ==== shared/hdt_pkg.sv ====
package hdt_pkg;
	typedef enum logic [2:0]
	{
		HDT_RD_IDLE = 3'b001,
		HDT_RD_RESP = 3'b010,
		HDT_RD_HOLD = 3'b100
	} hdt_rd_state_t;
	typedef logic [7:0] hdt_char_t;
endpackage

// ==== hdl/hdt_horizontal_timing.sv ====
// Operation
// - Active width in characters minus one comes from bits 10:3; bits 2:0 ignored.
// - Active width only in steps of eight pixels.
// - One active and one total setting drive both CRT and panel outputs.
// - Blank end taken from bits 26:19 of blank register; 18:16 ignored.
// - Blank end only on eight-pixel boundaries.
// - Blank start taken from bits 10:3 of blank register; 2:0 ignored.
// - Blank start only on eight-pixel boundaries.
// - Sync end taken from bits 26:19 of sync register; 18:16 ignored.
// - Sync end only on eight-pixel boundaries.
// - Line total in characters minus one from bits 26:19 of first register.
// - One character clock is eight pixels; all counts in characters.
`timescale 1ns/1ns
`include "hdt_cfg.svh"
module hdt_horizontal_timing
	import hdt_pkg::*;
#(
	parameter int PIX_PER_CHAR = `HDT_PIX_PER_CHAR
)
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        pixel_en,
	input  wire logic [15:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [15:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [7:0]       char_count,
	output logic             line_start,
	output logic             active_video,
	output logic             blank_out,
	output logic             crt_hsync,
	output logic             panel_active
);
	// Sync start comes from bits 10:3 of the sync register, held in sync_begin_pos.
	localparam int SYNC_BEGIN_LSB = `HDT_LO_LSB;

	logic [31:0]   horiz_total_active;
	logic [31:0]   horiz_blank_window;
	logic [31:0]   horiz_sync_window;
	logic [15:0]   aw_addr;
	logic          aw_held;
	logic [31:0]   w_data;
	logic [3:0]    w_strb;
	logic          w_held;
	logic [15:0]   ar_addr;
	hdt_rd_state_t rd_state;
	hdt_char_t     pix_phase;
	logic          char_en;
	hdt_char_t     count;
	hdt_char_t     total_pos;
	hdt_char_t     active_pos;
	hdt_char_t     blank_begin_pos;
	hdt_char_t     blank_stop_pos;
	hdt_char_t     sync_begin_pos;
	hdt_char_t     sync_stop_pos;
	hdt_char_t     next_count;
	logic          wr_fire;
	logic          next_blank;
	logic          next_hsync;

	// One-hot select of the three timing registers; none set means unmapped
	function automatic logic [2:0] hdt_reg_sel(input logic [15:0] a);
		hdt_reg_sel = {a == `HDT_OFF_SYNC_WINDOW, a == `HDT_OFF_BLANK_WINDOW, a == `HDT_OFF_TOTAL_ACTIVE};
	endfunction

	function automatic logic hdt_addr_ok(input logic [15:0] a);
		hdt_addr_ok = |hdt_reg_sel(a);
	endfunction

	function automatic logic [31:0] hdt_merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (s[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		end
		hdt_merge = r;
	endfunction

	// Character fields: the low three pixel bits are never stored in the compare
	function automatic hdt_char_t hdt_hi(input logic [31:0] r);
		hdt_hi = r[`HDT_HI_MSB:`HDT_HI_LSB];
	endfunction

	function automatic hdt_char_t hdt_lo(input logic [31:0] r);
		hdt_lo = r[`HDT_LO_MSB:`HDT_LO_LSB];
	endfunction

	// Write address and data accepted in either order
	// Latched a cycle before ready; safe since valid must hold till then
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held       <= 1'b0;
			aw_addr       <= 16'h0000;
			s_axi_awready <= 1'b0;
		end
		else
		begin
			s_axi_awready <= 1'b0;
			if (s_axi_bvalid && s_axi_bready)
				aw_held <= 1'b0;
			else if (s_axi_awvalid && !aw_held && !s_axi_awready)
			begin
				aw_held       <= 1'b1;
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held       <= 1'b0;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			s_axi_wready <= 1'b0;
		end
		else
		begin
			s_axi_wready <= 1'b0;
			if (s_axi_bvalid && s_axi_bready)
				w_held <= 1'b0;
			else if (s_axi_wvalid && !w_held && !s_axi_wready)
			begin
				w_held       <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Both halves held and no response pending
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;

	// Registers come up zero; their true reset value is undefined
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			horiz_total_active <= 32'h00000000;
			horiz_blank_window <= 32'h00000000;
			horiz_sync_window  <= 32'h00000000;
		end
		else if (wr_fire)
		begin
			unique case (aw_addr)
				`HDT_OFF_TOTAL_ACTIVE: horiz_total_active <= hdt_merge(horiz_total_active, w_data, w_strb);
				`HDT_OFF_BLANK_WINDOW: horiz_blank_window <= hdt_merge(horiz_blank_window, w_data, w_strb);
				`HDT_OFF_SYNC_WINDOW:  horiz_sync_window  <= hdt_merge(horiz_sync_window, w_data, w_strb);
				default: ;
			endcase
		end
	end

	// Write response follows both halves
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `HDT_RESP_OKAY;
		end
		else if (s_axi_bvalid)
		begin
			if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= hdt_addr_ok(aw_addr) ? `HDT_RESP_OKAY : `HDT_RESP_SLVERR;
		end
	end

	// Read channel
	// Unmapped reads return the live count, useful when bringing up timing
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_state      <= HDT_RD_IDLE;
			ar_addr       <= 16'h0000;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `HDT_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= 1'b0;
			unique case (rd_state)
				HDT_RD_IDLE:
				begin
					if (s_axi_arvalid)
					begin
						ar_addr       <= s_axi_araddr;
						s_axi_arready <= 1'b1;
						rd_state      <= HDT_RD_RESP;
					end
				end
				HDT_RD_RESP:
				begin
					s_axi_rvalid <= 1'b1;
					s_axi_rresp  <= hdt_addr_ok(ar_addr) ? `HDT_RESP_OKAY : `HDT_RESP_SLVERR;
					unique case (ar_addr)
						`HDT_OFF_TOTAL_ACTIVE: s_axi_rdata <= horiz_total_active;
						`HDT_OFF_BLANK_WINDOW: s_axi_rdata <= horiz_blank_window;
						`HDT_OFF_SYNC_WINDOW:  s_axi_rdata <= horiz_sync_window;
						default:               s_axi_rdata <= {24'h000000, count};
					endcase
					rd_state <= HDT_RD_HOLD;
				end
				HDT_RD_HOLD:
				begin
					if (s_axi_rready)
					begin
						s_axi_rvalid <= 1'b0;
						rd_state     <= HDT_RD_IDLE;
					end
				end
				default: rd_state <= HDT_RD_IDLE;
			endcase
		end
	end

	assign total_pos       = hdt_hi(horiz_total_active);
	assign active_pos      = hdt_lo(horiz_total_active);
	assign blank_stop_pos  = hdt_hi(horiz_blank_window);
	assign blank_begin_pos = hdt_lo(horiz_blank_window);
	assign sync_stop_pos   = hdt_hi(horiz_sync_window);
	assign sync_begin_pos  = horiz_sync_window[`HDT_LO_MSB:SYNC_BEGIN_LSB];

	// Pixel enable divided by eight gives the character clock
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pix_phase <= 8'h00;
		else if (char_en)
			pix_phase <= 8'h00;
		else if (pixel_en)
			pix_phase <= pix_phase + 8'h01;
	end

	assign char_en    = pixel_en && (pix_phase == hdt_char_t'(PIX_PER_CHAR - 1));
	assign next_count = (count >= total_pos) ? 8'h00 : count + 8'h01;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count <= 8'h00;
		else if (char_en)
			count <= next_count;
	end

	// Outputs registered from the counter; compares are on count just updated
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			char_count <= 8'h00;
			line_start <= 1'b0;
		end
		else
		begin
			line_start <= char_en && (next_count == 8'h00);
			if (char_en)
				char_count <= next_count;
		end
	end

	// Both displays follow one active compare
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			active_video <= 1'b0;
			panel_active <= 1'b0;
		end
		else if (char_en)
		begin
			active_video <= (next_count <= active_pos);
			panel_active <= (next_count <= active_pos);
		end
	end

	// Set wins when start and end compares hit together
	always_comb
	begin
		next_blank = blank_out;
		if (next_count == blank_begin_pos)
			next_blank = 1'b1;
		else if (next_count == blank_stop_pos)
			next_blank = 1'b0;
	end

	always_comb
	begin
		next_hsync = crt_hsync;
		if (next_count == sync_begin_pos)
			next_hsync = 1'b1;
		else if (next_count == sync_stop_pos)
			next_hsync = 1'b0;
	end

	// Window held across wrap; equal start and end leaves it set
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			blank_out <= 1'b0;
		else if (char_en)
			blank_out <= next_blank;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			crt_hsync <= 1'b0;
		else if (char_en)
			crt_hsync <= next_hsync;
	end
endmodule

// ==== tb/hdt_horizontal_timing_chk.sv ====
`timescale 1ns/1ns
module hdt_horizontal_timing_chk
(
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic [7:0] char_count,
	input wire logic       line_start,
	input wire logic       active_video,
	input wire logic       panel_active,
	input wire logic       blank_out,
	input wire logic       crt_hsync
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_axi_awready && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arready;
	endsequence
	a_panel_mirror:
		assert property (panel_active == active_video) else $error("panel differs");
	a_count_step:
		assert property ($changed(char_count) |-> char_count == $past(char_count) + 8'h01 || char_count == 8'h00)
		else $error("count step");
	// Fewer pixel enables only stretch the dwell, so seven is a floor
	a_count_dwell:
		assert property ($changed(char_count) |=> $stable(char_count) [*7]) else $error("count dwell");
	a_blank_dwell:
		assert property ($changed(blank_out) |=> $stable(blank_out) [*7]) else $error("blank dwell");
	a_sync_dwell:
		assert property ($changed(crt_hsync) |=> $stable(crt_hsync) [*7]) else $error("sync dwell");
	a_line_zero:
		assert property (line_start |-> ##[0:1] char_count == 8'h00) else $error("wrap not zero");
	a_start_single:
		assert property (line_start |=> !line_start) else $error("line pulse");
	a_aw_single:
		assert property (s_axi_awready |=> !s_axi_awready) else $error("awready");
	a_write_answer:
		assert property (s_wr_taken |-> ##1 s_axi_bvalid) else $error("no bvalid");
	a_read_answer:
		assert property (s_rd_taken |-> ##1 s_axi_rvalid) else $error("no rvalid");
	a_b_clear:
		assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
	a_r_clear:
		assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
endmodule
bind hdt_horizontal_timing hdt_horizontal_timing_chk u_chk(.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .char_count, .line_start,
	.active_video, .panel_active, .blank_out, .crt_hsync);

// ==== tb/hdt_display_mon.sv ====
`timescale 1ns/1ns
module hdt_display_mon
(
	input  wire logic        aclk,
	input  wire logic        line_start,
	input  wire logic        active_video,
	input  wire logic        blank_out,
	input  wire logic        crt_hsync,
	output logic      [31:0] len,
	output logic      [31:0] act,
	output logic      [31:0] blk,
	output logic      [31:0] syn
);
	logic [31:0] nl;
	logic [31:0] na;
	logic [31:0] nb;
	logic [31:0] ns;
	// One whole line per window, so output phase does not matter
	always_ff @(posedge aclk)
	begin
		if (line_start)
		begin
			len <= nl;
			act <= na;
			blk <= nb;
			syn <= ns;
			nl <= 32'h1;
			na <= {31'h0, active_video};
			nb <= {31'h0, blank_out};
			ns <= {31'h0, crt_hsync};
		end
		else
		begin
			nl <= nl + 32'h1;
			na <= na + {31'h0, active_video};
			nb <= nb + {31'h0, blank_out};
			ns <= ns + {31'h0, crt_hsync};
		end
	end
endmodule

// ==== tb/tb_hdt_horizontal_timing.sv ====
`timescale 1ns/1ns
`include "hdt_cfg.svh"
module tb_horizontal_display_timing;
	logic        aclk, aresetn, pixel_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        line_start, active_video, blank_out, crt_hsync, panel_active;
	logic [15:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, mon_len, mon_act, mon_blk, mon_syn;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  char_count;
	int          err_count, n_checks;
	hdt_horizontal_timing DUT(.aclk, .aresetn, .pixel_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .char_count, .line_start, .active_video, .blank_out, .crt_hsync, .panel_active);
	hdt_display_mon u_mon(.aclk, .line_start, .active_video, .blank_out, .crt_hsync,
		.len(mon_len), .act(mon_act), .blk(mon_blk), .syn(mon_syn));
	task final_report;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask
	// Ready is sampled mid-cycle, where it is settled, and acted on at the next edge
	task wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w))
		begin
			@(negedge aclk);
			aw = aw | s_axi_awready;
			w = w | s_axi_wready;
			@(posedge aclk);
			s_axi_awvalid <= !aw;
			s_axi_wvalid <= !w;
		end
		do @(negedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge aclk); while (!s_axi_arready);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask
	task t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		for (int i = 0; i < 3; i++)
		begin
			wr(`HDT_OFF_TOTAL_ACTIVE + 16'(4 * i), 32'h07ff07ff - 32'(i), r);
			chk({30'h0, r}, {30'h0, `HDT_RESP_OKAY});
			rd(`HDT_OFF_TOTAL_ACTIVE + 16'(4 * i), d, r);
			chk(d, 32'h07ff07ff - 32'(i));
			chk({30'h0, r}, {30'h0, `HDT_RESP_OKAY});
		end
		wr(16'h8340, 32'h1, r);
		chk({30'h0, r}, {30'h0, `HDT_RESP_SLVERR});
		rd(16'h8340, d, r);
		chk({30'h0, r}, {30'h0, `HDT_RESP_SLVERR});
	endtask
	// Ignored low bits carry junk on purpose
	task t_line(input logic [7:0] t, a, s, e, ss, se);
		logic [1:0] r;
		wr(`HDT_OFF_TOTAL_ACTIVE, {5'h0, t, 3'h7, 5'h0, a, 3'h7}, r);
		wr(`HDT_OFF_BLANK_WINDOW, {5'h0, e, 3'h5, 5'h0, s, 3'h2}, r);
		wr(`HDT_OFF_SYNC_WINDOW, {5'h0, se, 3'h1, 5'h0, ss, 3'h6}, r);
		repeat (3) @(negedge aclk iff line_start);
		@(negedge aclk);
		chk(mon_len, (t + 1) * 8);
		chk(mon_act, (a + 1) * 8);
		chk(mon_blk, (e - s) * 8);
		chk(mon_syn, (se - ss) * 8);
	endtask
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	initial
	begin
		#1000000;
		err_count++;
		final_report;
	end
	initial
	begin
		{aresetn, pixel_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
		s_axi_wstrb = 4'hf;
		err_count = 0;
		n_checks = 0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		pixel_en <= 1'b1;
		t_regs;
		t_line(8'd19, 8'd9, 8'd10, 8'd18, 8'd12, 8'd15);
		t_line(8'd15, 8'd7, 8'd9, 8'd14, 8'd10, 8'd12);
		final_report;
	end
endmodule
